// >>> ctb_pkg.sv
// Purpose: Shared constants and carrier types for the CAN transmit buffer bookkeeping block.
// Assumes: AHB-Lite register access with 32-bit data, one register per aligned word.
// Notes: Printed offsets are not all multiples of four, so they are kept as word indices.
package ctb_pkg;
    localparam int CTB_NBUF = 3;
    localparam logic [7:0] CTB_IDX_TFLG = 8'h06;
    localparam logic [7:0] CTB_IDX_TIER = 8'h07;
    localparam logic [7:0] CTB_IDX_TARQ = 8'h08;
    localparam logic [7:0] CTB_IDX_TAAK = 8'h09;
    localparam logic [7:0] CTB_IDX_CTRL = 8'h0A;
    localparam logic [7:0] CTB_IDX_STAT = 8'h0B;
    localparam logic [7:0] CTB_IDX_IMSK = 8'h0C;
    localparam logic [7:0] CTB_IDX_EVT = 8'h0D;
    localparam logic [2:0] CTB_TFLG_RESET = 3'h7;
    localparam logic [2:0] CTB_TIER_RESET = 3'h0;
    localparam logic [2:0] CTB_TARQ_RESET = 3'h0;
    localparam int CTB_CTRL_INIT_REQUEST_BIT = 0;
    localparam int CTB_CTRL_LISTEN_BIT = 1;
    localparam int CTB_CTRL_SEL_LSB = 4;
    localparam int CTB_EVT_BIT_DONE = 0;
    localparam int CTB_EVT_BIT_ABORT = 1;
    localparam logic [1:0] CTB_HTRANS_NONSEQ = 2'h2;

    // Per-buffer report from the protocol engine, one-cycle pulses.
    typedef struct packed {
        logic [2:0] sent;
        logic [2:0] abort_ok;
    } ctb_eng_s;

    typedef struct packed {
        logic init_request;
        logic listen;
    } ctb_mode_s;
endpackage

// >>> ctb_sync_ack.sv
// Purpose: Init acknowledge generator: follows the init request after a two-stage settle.
// Assumes: Request is synchronous to hclk.
// Notes: Acknowledge rises two cycles after request rises and falls two cycles after it falls.
`timescale 1ns/1ps
module ctb_sync_ack
    import ctb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    output logic ack
);
    logic stage_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_q <= 1'b0;
            ack <= 1'b0;
        end else begin
            stage_q <= req;
            ack <= stage_q;
        end
    end
endmodule

// >>> ctb_top.sv
// Purpose: Transmit buffer empty flags, empty interrupt enables and abort requests of a CAN node.
// Assumes: AHB-Lite single word transfers; protocol engine pulses arrive synchronous to hclk.
// Notes: Registers answer with zero wait states; unmapped words read zero, writes ignored.
// Operation
// - Writing one clears an empty flag; writing zero leaves it.
// - Empty flags held at reset in init mode; writable only outside it.
// - Interrupt enables held at reset in init mode; writable afterwards.
// - Abort request register at index 0x08, three low bits, resets zero.
// - Empty flag sets after a successful transmission.
// - Empty flag sets after a granted abort.
// - Transmit interrupt stays high while an enabled empty flag is set.
// - Each enable bit gates its buffer's empty interrupt.
// - Clearing an empty flag clears its abort acknowledge.
// - Setting an empty flag clears its abort request.
// - In listen mode flags cannot be cleared and no transmission starts.
// - Buffer access blocked while its flag is zero and scheduled.
// - One empty flag per buffer in bits two to zero.
// - Abort granted only before start or after failure; software cannot clear.
// - Granted abort sets the buffer's abort acknowledge flag.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
module ctb_top
    import ctb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ctb_eng_s eng,
    input wire logic [2:0] eng_abortable,
    output logic [2:0] tx_schedule,
    output logic [2:0] tx_abort_pending,
    output logic buf_access_ok,
    output logic init_acknowledge,
    output logic tx_irq,
    output logic evt_irq
);
    logic [2:0] tx_buffer_empty_q;
    logic [2:0] tx_empty_irq_en_q;
    logic [2:0] abort_request_q;
    logic [2:0] abort_acknowledge_q;
    ctb_mode_s mode_q;
    logic [2:0] buf_sel_q;
    logic [1:0] evt_stat_q;
    logic [1:0] evt_mask_q;
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic ack_w;
    logic in_init;
    logic out_init;
    logic wr_go;
    logic rd_go;
    logic [7:0] a_idx;
    logic [2:0] wdat3;
    logic [2:0] clr_txe;
    logic [2:0] set_txe;
    logic [2:0] grant;
    logic [2:0] sel_low;

    ctb_sync_ack ctb_sync_ack_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(mode_q.init_request),
        .ack(ack_w)
    );

    assign in_init = mode_q.init_request & ack_w;
    assign out_init = !mode_q.init_request & !ack_w;
    assign a_idx = haddr[9:2];
    assign rd_go = hsel & hready & (htrans == CTB_HTRANS_NONSEQ) & !hwrite;
    assign wr_go = wr_pend_q;
    assign wdat3 = hwdata[2:0];
    // An abort is granted only when the engine says the message is idle or failed.
    assign grant = abort_request_q & ~tx_buffer_empty_q & eng_abortable
                 & ~eng.sent;
    // Listen mode discards every clear of an empty flag.
    assign clr_txe = (wr_go && wr_idx_q == CTB_IDX_TFLG && out_init && !mode_q.listen)
                   ? wdat3 : 3'h0;
    assign set_txe = (eng.sent | grant) & ~tx_buffer_empty_q;
    assign sel_low = buf_sel_q & (~buf_sel_q + 3'h1);

    // Write address phase captured for the following data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
        end else begin
            wr_pend_q <= hsel & hready & (htrans == CTB_HTRANS_NONSEQ) & hwrite;
            wr_idx_q <= a_idx;
        end
    end

    // Control word: init request is writable always, so software can leave init.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= '{init_request: 1'b1, listen: 1'b0};
            buf_sel_q <= 3'h0;
        end else if (wr_go && wr_idx_q == CTB_IDX_CTRL) begin
            mode_q.init_request <= hwdata[CTB_CTRL_INIT_REQUEST_BIT];
            mode_q.listen <= hwdata[CTB_CTRL_LISTEN_BIT];
            buf_sel_q <= in_init ? 3'h0 : hwdata[CTB_CTRL_SEL_LSB +: 3];
        end else if (in_init) begin
            buf_sel_q <= 3'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_buffer_empty_q <= CTB_TFLG_RESET;
        end else if (in_init) begin
            tx_buffer_empty_q <= CTB_TFLG_RESET;
        end else begin
            // One flag per buffer; hardware set wins over a same-cycle clear.
            tx_buffer_empty_q <= (tx_buffer_empty_q & ~clr_txe) | set_txe;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_empty_irq_en_q <= CTB_TIER_RESET;
        end else if (in_init) begin
            tx_empty_irq_en_q <= CTB_TIER_RESET;
        end else if (wr_go && wr_idx_q == CTB_IDX_TIER && out_init) begin
            tx_empty_irq_en_q <= wdat3;
        end
    end

    // Software can only set request bits; only a set empty flag or init mode clears them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_request_q <= CTB_TARQ_RESET;
        end else if (in_init) begin
            abort_request_q <= CTB_TARQ_RESET;
        end else begin
            abort_request_q <= (abort_request_q
                | ((wr_go && wr_idx_q == CTB_IDX_TARQ && out_init) ? wdat3 : 3'h0))
                & ~set_txe;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_acknowledge_q <= 3'h0;
        end else if (in_init) begin
            abort_acknowledge_q <= 3'h0;
        end else begin
            abort_acknowledge_q <= (abort_acknowledge_q & ~clr_txe) | (grant & set_txe);
        end
    end

    // Event status: done and abort events, write one to clear, set wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_stat_q <= 2'h0;
            evt_mask_q <= 2'h0;
        end else begin
            evt_stat_q[CTB_EVT_BIT_DONE] <= (evt_stat_q[CTB_EVT_BIT_DONE]
                & !(wr_go && wr_idx_q == CTB_IDX_STAT && hwdata[CTB_EVT_BIT_DONE]))
                | |(eng.sent & set_txe);
            evt_stat_q[CTB_EVT_BIT_ABORT] <= (evt_stat_q[CTB_EVT_BIT_ABORT]
                & !(wr_go && wr_idx_q == CTB_IDX_STAT && hwdata[CTB_EVT_BIT_ABORT]))
                | |(grant & set_txe);
            if (wr_go && wr_idx_q == CTB_IDX_IMSK) begin
                evt_mask_q <= hwdata[1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_schedule <= 3'h0;
            tx_abort_pending <= 3'h0;
            buf_access_ok <= 1'b0;
            init_acknowledge <= 1'b0;
            tx_irq <= 1'b0;
            evt_irq <= 1'b0;
        end else begin
            // Current register values feed the outputs, so they trail the flags by one cycle.
            tx_schedule <= mode_q.listen ? 3'h0 : ~tx_buffer_empty_q;
            tx_abort_pending <= abort_request_q;
            buf_access_ok <= |(sel_low & tx_buffer_empty_q);
            init_acknowledge <= ack_w;
            tx_irq <= |(tx_buffer_empty_q & tx_empty_irq_en_q);
            evt_irq <= |(evt_stat_q & evt_mask_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            if (rd_go) begin
                case (a_idx)
                    CTB_IDX_TFLG: hrdata <= {29'h0, tx_buffer_empty_q};
                    CTB_IDX_TIER: hrdata <= {29'h0, tx_empty_irq_en_q};
                    CTB_IDX_TARQ: hrdata <= {29'h0, abort_request_q};
                    CTB_IDX_TAAK: hrdata <= {29'h0, abort_acknowledge_q};
                    CTB_IDX_CTRL: hrdata <= {25'h0, sel_low, 1'b0, ack_w,
                                             mode_q.listen, mode_q.init_request};
                    CTB_IDX_STAT: hrdata <= {30'h0, evt_stat_q};
                    CTB_IDX_IMSK: hrdata <= {30'h0, evt_mask_q};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    property p_set_clears_req;
        @(posedge hclk) disable iff (!hresetn)
        (set_txe != 3'h0 && !in_init) |=> ((abort_request_q & $past(set_txe)) == 3'h0);
    endproperty
    a_set_clears_req: assert property (p_set_clears_req)
        else $error("abort request not cleared by empty flag set");

    property p_irq_follow;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> tx_irq == |($past(tx_buffer_empty_q) & $past(tx_empty_irq_en_q));
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("tx irq does not follow enabled empty flags");

    property p_init_hold;
        @(posedge hclk) disable iff (!hresetn)
        in_init |=> tx_buffer_empty_q == CTB_TFLG_RESET && tx_empty_irq_en_q == 3'h0;
    endproperty
    a_init_hold: assert property (p_init_hold)
        else $error("registers not held during init");

    property p_listen_noclr;
        @(posedge hclk) disable iff (!hresetn)
        (mode_q.listen && !in_init) |=> ((~tx_buffer_empty_q & $past(tx_buffer_empty_q)) == 3'h0);
    endproperty
    a_listen_noclr: assert property (p_listen_noclr)
        else $error("empty flag cleared in listen mode");

    property p_w1c;
        @(posedge hclk) disable iff (!hresetn)
        (clr_txe != 3'h0 && set_txe == 3'h0 && !in_init) |=> ((tx_buffer_empty_q & $past(clr_txe)) == 3'h0);
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear empty flag");

    property p_ack_clr;
        @(posedge hclk) disable iff (!hresetn)
        (clr_txe != 3'h0 && !in_init) |=> ((abort_acknowledge_q & $past(clr_txe) & ~$past(set_txe)) == 3'h0);
    endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("abort acknowledge survived flag clear");

    property p_grant_ack;
        @(posedge hclk) disable iff (!hresetn)
        (grant != 3'h0 && !in_init) |=> ((abort_acknowledge_q & tx_buffer_empty_q & $past(grant)) == $past(grant));
    endproperty
    a_grant_ack: assert property (p_grant_ack)
        else $error("granted abort did not set empty and acknowledge");

    property p_sent_sets;
        @(posedge hclk) disable iff (!hresetn)
        (eng.sent != 3'h0 && !in_init) |=> ((tx_buffer_empty_q & $past(eng.sent)) == $past(eng.sent));
    endproperty
    a_sent_sets: assert property (p_sent_sets)
        else $error("sent buffer not flagged empty");

    property p_req_sticky;
        @(posedge hclk) disable iff (!hresetn)
        !in_init |=> ((~abort_request_q & $past(abort_request_q) & ~$past(set_txe)) == 3'h0);
    endproperty
    a_req_sticky: assert property (p_req_sticky)
        else $error("abort request dropped without an empty flag set");

    property p_flag_rise;
        @(posedge hclk) disable iff (!hresetn)
        !in_init |=>
            ((tx_buffer_empty_q & ~$past(tx_buffer_empty_q) & ~$past(set_txe)) == 3'h0);
    endproperty
    a_flag_rise: assert property (p_flag_rise)
        else $error("empty flag rose without an engine event");

    property p_init_clear;
        @(posedge hclk) disable iff (!hresetn)
        in_init |=> abort_request_q == CTB_TARQ_RESET && abort_acknowledge_q == 3'h0;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("abort registers not held during init");

    property p_access_block;
        @(posedge hclk) disable iff (!hresetn)
        (sel_low & tx_buffer_empty_q) == 3'h0 |=> !buf_access_ok;
    endproperty
    a_access_block: assert property (p_access_block)
        else $error("buffer access allowed while scheduled or unselected");

    property p_listen_idle;
        @(posedge hclk) disable iff (!hresetn)
        mode_q.listen |=> tx_schedule == 3'h0;
    endproperty
    a_listen_idle: assert property (p_listen_idle)
        else $error("transmission scheduled in listen mode");

    property p_irq_hold;
        @(posedge hclk) disable iff (!hresetn)
        (tx_buffer_empty_q & tx_empty_irq_en_q) != 3'h0 |=> tx_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("tx irq low while an enabled empty flag is set");

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        (tx_buffer_empty_q & tx_empty_irq_en_q) == 3'h0 |=> !tx_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("tx irq raised by a masked empty flag");

    // A finished send settles in two steps: flag up and request gone, then the schedule drops.
    sequence s_send_seen;
        (eng.sent & set_txe) != 3'h0 && !in_init;
    endsequence

    sequence s_send_settled;
        ((tx_buffer_empty_q & ~abort_request_q & $past(set_txe)) == $past(set_txe))
        ##1 ((tx_schedule & $past(set_txe, 2)) == 3'h0);
    endsequence

    property p_send_flow;
        @(posedge hclk) disable iff (!hresetn)
        s_send_seen |=> s_send_settled;
    endproperty
    a_send_flow: assert property (p_send_flow)
        else $error("sent buffer did not settle");

    // A granted abort settles the same way, with the acknowledge raised alongside the flag.
    sequence s_abort_granted;
        grant != 3'h0 && !in_init;
    endsequence

    sequence s_abort_settled;
        ((abort_acknowledge_q & tx_buffer_empty_q & $past(grant)) == $past(grant))
        ##1 ((tx_schedule & $past(grant, 2)) == 3'h0);
    endsequence

    property p_abort_flow;
        @(posedge hclk) disable iff (!hresetn)
        s_abort_granted |=> s_abort_settled;
    endproperty
    a_abort_flow: assert property (p_abort_flow)
        else $error("granted abort did not settle");
endmodule

// >>> ctb_eng_model.sv
// Purpose: Behavioural protocol engine facing the transmit buffer bookkeeping block.
// Assumes: Scheduled buffers are seen on tx_schedule, all in the hclk domain.
// Notes: No frame starts while hold is high, which leaves room for abort grants.
`timescale 1ns/1ps
module ctb_eng_model
    import ctb_pkg::*;
#(
    parameter int DELAY = 4
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] tx_schedule,
    input wire logic hold,
    input wire logic grant_ok,
    output ctb_eng_s eng,
    output logic [2:0] eng_abortable
);
    int cnt [3];
    // A held message has not started, so it may be withdrawn when the bench allows it.
    assign eng_abortable = {3{hold & grant_ok}};
    // DELAY of two or more keeps the late drop of tx_schedule from causing a second pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eng <= '0;
            cnt <= '{0, 0, 0};
        end else begin
            for (int i = 0; i < 3; i++) begin
                eng.sent[i] <= 1'b0;
                if (tx_schedule[i] && !hold) begin
                    if (cnt[i] == DELAY) begin
                        eng.sent[i] <= 1'b1;
                        cnt[i] <= 0;
                    end else begin
                        cnt[i] <= cnt[i] + 1;
                    end
                end else begin
                    cnt[i] <= 0;
                end
            end
        end
    end
endmodule

// >>> can_tx_buffer_flags_abort_test.sv
// Purpose: Register-level tests of transmit empty flags, enables and abort requests.
// Assumes: Zero wait AHB-Lite slave; engine model sends five cycles after tx_schedule rises.
// Notes: Buffer contents are not modelled; a clear of a flag stands for a loaded buffer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module can_tx_buffer_flags_abort_test;
    import ctb_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hold = 0, grant_ok = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic hreadyout, hresp, buf_access_ok, init_acknowledge, tx_irq, evt_irq;
    logic [2:0] tx_schedule, tx_abort_pending, eng_abortable;
    ctb_eng_s eng;
    int n_mismatch = 0, cmp_count = 0;
    ctb_top ctb_top_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eng(eng),
        .eng_abortable(eng_abortable), .tx_schedule(tx_schedule),
        .tx_abort_pending(tx_abort_pending), .buf_access_ok(buf_access_ok),
        .init_acknowledge(init_acknowledge), .tx_irq(tx_irq), .evt_irq(evt_irq));
    ctb_eng_model #(.DELAY(4)) ctb_eng_model_i(.hclk(hclk), .hresetn(hresetn),
        .tx_schedule(tx_schedule), .hold(hold), .grant_ok(grant_ok), .eng(eng),
        .eng_abortable(eng_abortable));
    initial begin
        forever #5 hclk = ~hclk;
    end
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= CTB_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0);
        `CHK($sformatf("reg %h", idx), e, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic waitflag(input logic [31:0] e);
        repeat (50) begin
            xfer(1'b0, CTB_IDX_TFLG, 32'h0);
            if (rd === e) break;
        end
        rdchk(CTB_IDX_TFLG, e);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        $display("watchdog expired");
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(CTB_IDX_TFLG, 32'h7);
        rdchk(CTB_IDX_TIER, 32'h0);
        rdchk(CTB_IDX_TARQ, 32'h0);
        `CHK("init_ack", 1'b1, init_acknowledge)
        xfer(1'b1, CTB_IDX_TFLG, 32'h7);
        rdchk(CTB_IDX_TFLG, 32'h7);
        xfer(1'b1, CTB_IDX_TIER, 32'h7);
        rdchk(CTB_IDX_TIER, 32'h0);
        xfer(1'b1, CTB_IDX_TARQ, 32'h7);
        rdchk(CTB_IDX_TARQ, 32'h0);
        xfer(1'b1, CTB_IDX_CTRL, 32'h0);
        repeat (5) @(posedge hclk);
        `CHK("init_ack", 1'b0, init_acknowledge)
        $display("test init done");
        xfer(1'b1, CTB_IDX_TIER, 32'h7);
        rdchk(CTB_IDX_TIER, 32'h7);
        repeat (2) @(posedge hclk);
        `CHK("tx_irq", 1'b1, tx_irq)
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, CTB_IDX_TIER, 32'h1 << i);
            repeat (2) @(posedge hclk);
            `CHK("tx_irq", 1'b1, tx_irq)
        end
        xfer(1'b1, CTB_IDX_TIER, 32'h0);
        repeat (2) @(posedge hclk);
        `CHK("tx_irq", 1'b0, tx_irq)
        $display("test enables done");
        xfer(1'b1, CTB_IDX_TIER, 32'h1);
        xfer(1'b1, CTB_IDX_TFLG, 32'h0);
        rdchk(CTB_IDX_TFLG, 32'h7);
        xfer(1'b1, CTB_IDX_TFLG, 32'h1);
        rdchk(CTB_IDX_TFLG, 32'h6);
        `CHK("tx_irq", 1'b0, tx_irq)
        waitflag(32'h7);
        repeat (2) @(posedge hclk);
        `CHK("tx_irq", 1'b1, tx_irq)
        xfer(1'b1, CTB_IDX_IMSK, 32'h1);
        repeat (2) @(posedge hclk);
        `CHK("evt_irq", 1'b1, evt_irq)
        xfer(1'b1, CTB_IDX_IMSK, 32'h0);
        repeat (2) @(posedge hclk);
        `CHK("evt_irq", 1'b0, evt_irq)
        xfer(1'b1, CTB_IDX_STAT, 32'h3);
        xfer(1'b1, CTB_IDX_IMSK, 32'h3);
        repeat (2) @(posedge hclk);
        `CHK("evt_irq", 1'b0, evt_irq)
        $display("test send done");
        hold <= 1'b1;
        xfer(1'b1, CTB_IDX_TFLG, 32'h2);
        xfer(1'b1, CTB_IDX_TARQ, 32'h2);
        repeat (2) @(posedge hclk);
        `CHK("abort_pending", 3'h2, tx_abort_pending)
        xfer(1'b1, CTB_IDX_TARQ, 32'h0);
        rdchk(CTB_IDX_TARQ, 32'h2);
        rdchk(CTB_IDX_TFLG, 32'h5);
        grant_ok <= 1'b1;
        waitflag(32'h7);
        rdchk(CTB_IDX_TARQ, 32'h0);
        rdchk(CTB_IDX_TAAK, 32'h2);
        rdchk(CTB_IDX_STAT, 32'h2);
        grant_ok <= 1'b0;
        xfer(1'b1, CTB_IDX_TFLG, 32'h2);
        rdchk(CTB_IDX_TAAK, 32'h0);
        xfer(1'b1, CTB_IDX_TARQ, 32'h2);
        hold <= 1'b0;
        waitflag(32'h7);
        rdchk(CTB_IDX_TARQ, 32'h0);
        rdchk(CTB_IDX_TAAK, 32'h0);
        $display("test abort done");
        hold <= 1'b1;
        xfer(1'b1, CTB_IDX_TFLG, 32'h1);
        xfer(1'b1, CTB_IDX_CTRL, 32'h30);
        rdchk(CTB_IDX_CTRL, 32'h10);
        repeat (2) @(posedge hclk);
        `CHK("buf_access_ok", 1'b0, buf_access_ok)
        hold <= 1'b0;
        waitflag(32'h7);
        repeat (2) @(posedge hclk);
        `CHK("buf_access_ok", 1'b1, buf_access_ok)
        hold <= 1'b1;
        xfer(1'b1, CTB_IDX_TFLG, 32'h1);
        xfer(1'b1, CTB_IDX_CTRL, 32'h2);
        xfer(1'b1, CTB_IDX_TFLG, 32'h7);
        rdchk(CTB_IDX_TFLG, 32'h6);
        hold <= 1'b0;
        repeat (12) @(posedge hclk);
        `CHK("tx_schedule", 3'h0, tx_schedule)
        rdchk(CTB_IDX_TFLG, 32'h6);
        xfer(1'b1, CTB_IDX_CTRL, 32'h1);
        repeat (5) @(posedge hclk);
        rdchk(CTB_IDX_TFLG, 32'h7);
        rdchk(CTB_IDX_TIER, 32'h0);
        $display("test listen done");
        report_and_stop;
    end
endmodule
